// ==== logic/lmfc_frame_ctrl.sv ====
// multiplexed lcd frame controller: mode register, scan sequencer, line drive
`timescale 1ns/1ps
// Notes on behaviour
// - ratio bits pick 1/8, 1/11 or 1/16 commons; both set is reserved
// - base frame rate is the 32 kHz clock divided by a selectable ratio
// - base codes 01,10,00,11 give 128, 170, 256, 512 Hz
// - frame rate equals base at 1/8, lower at 1/11, half at 1/16
// - mode register at DCh: ratio 7-6, divider 5-3, reserved 2, base 1-0
// - in 1/8 and 1/11 the two middle bias levels are merged
// - matrix is 48 by 8, or 40 by 11 or 16
// - display memory sits at 00h to 3Fh in two 64-byte pages
// - address picks column; page 1 bits feed commons 1-8, page 2 commons 9-16
// - a set bit turns its dot on, a clear bit turns it off
// - 1/8 mode fetches page 1 only
// - 1/16 mode fetches both pages but skips addresses 00 to 07
// - 1/11 mode also leaves page 2 bits 3 to 7 unused
// - addresses 38h to 3Fh are never displayed
// - reset clears the mode register, display off, memory untouched
// - stop mode grounds every segment and common line
// - divider codes 000 off, 011 /32, 100 /64, 101 /128, 110 /256
// - oscillator failure grounds every segment and common line
module lmfc_frame_ctrl
	import lmfc_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire lmfc_pkg::lmfc_cpu_req_t cpu_req,
	output logic [7:0]                   cpu_rdata,
	input  wire logic                    stop_mode,
	input  wire logic                    osc_fail_async,
	output logic [47:0]                  seg_lines,
	output logic [15:0]                  common_plate_lines,
	output logic                         lines_driven,
	output logic                         bias_merge
);
	typedef enum logic [1:0] {
		LMFC_ST_IDLE  = 2'b00,
		LMFC_ST_FETCH = 2'b01,
		LMFC_ST_LATCH = 2'b10
	} lmfc_state_t;

	// ****************************************
	// reset release and pin synchroniser
	// ****************************************
	logic rst_meta_ff;
	logic rst_sync_n;
	logic fail_meta_ff;
	logic fail_sync_ff;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_n  <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_n  <= rst_meta_ff;
		end
	end

	// failure flag comes from the clock supervisor, outside this domain
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			fail_meta_ff <= 1'b0;
			fail_sync_ff <= 1'b0;
		end
		else
		begin
			fail_meta_ff <= osc_fail_async;
			fail_sync_ff <= fail_meta_ff;
		end
	end

	// ****************************************
	// mode register and cpu port
	// ****************************************
	lmfc_ctrl_t ctrl_ff;
	lmfc_ctrl_t nxt_ctrl;
	logic       rd_ctrl_ff;
	logic       nxt_rd_ctrl;
	logic [7:0] ctrl_rd_ff;
	logic [7:0] nxt_ctrl_rd;
	logic       ram_sel;
	logic       ctrl_sel;
	logic [7:0] ram_cpu_rdata;

	// register write strips the reserved bit so it always reads zero
	always_comb
	begin
		ram_sel     = cpu_req.addr <= LMFC_RAM_LAST_ADDR;
		ctrl_sel    = cpu_req.addr == LMFC_CTRL_ADDR;
		nxt_ctrl    = ctrl_ff;
		if (cpu_req.wr && ctrl_sel)
			nxt_ctrl = lmfc_ctrl_t'(cpu_req.wdata & ~LMFC_CTRL_RSVD_MSK);
		nxt_rd_ctrl = cpu_req.rd ? !ram_sel : rd_ctrl_ff;
		nxt_ctrl_rd = !cpu_req.rd ? ctrl_rd_ff : ctrl_sel ? ctrl_ff : 8'h00;
	end

	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctrl_ff    <= lmfc_ctrl_t'(LMFC_CTRL_RESET);
			rd_ctrl_ff <= 1'b0;
			ctrl_rd_ff <= 8'h00;
		end
		else
		begin
			ctrl_ff    <= nxt_ctrl;
			rd_ctrl_ff <= nxt_rd_ctrl;
			ctrl_rd_ff <= nxt_ctrl_rd;
		end
	end

	// read data one cycle after the request; unmapped addresses read zero
	assign cpu_rdata = rd_ctrl_ff ? ctrl_rd_ff : ram_cpu_rdata;

	// ****************************************
	// enable and rate chain
	// ****************************************
	logic       active;
	logic       slot_tick;
	logic [4:0] ncom;
	logic       wide;

	// reserved ratio or a stopped divider leaves the panel grounded
	always_comb
	begin
		ncom   = lmfc_common_count(ctrl_ff.ratio);
		wide   = ctrl_ff.ratio == LMFC_MUX8;
		active = (ncom != 5'h00) && (lmfc_osc_div(ctrl_ff.osc_div) != 9'h000)
			&& !stop_mode && !fail_sync_ff;
	end

	lmfc_rate_gen u_rate (
		.mclk       (mclk),
		.rst_sync_n (rst_sync_n),
		.run        (active),
		.osc_code   (ctrl_ff.osc_div),
		.base_code  (ctrl_ff.base_rate),
		.slot_tick  (slot_tick)
	);

	// ****************************************
	// scan sequencer
	// ****************************************
	lmfc_state_t state_ff;
	lmfc_state_t nxt_state;
	logic [3:0]  com_ff;
	logic [3:0]  nxt_com;
	logic [5:0]  col_ff;
	logic [5:0]  nxt_col;
	logic        pend_ff;
	logic        nxt_pend;
	logic [5:0]  pend_col_ff;
	logic [47:0] shadow_ff;
	logic [47:0] nxt_shadow;
	logic [47:0] seg_ff;
	logic [47:0] nxt_seg;
	logic [15:0] cpl_ff;
	logic [15:0] nxt_cpl;
	logic        drv_ff;
	logic        nxt_drv;
	logic        merge_ff;
	logic        nxt_merge;
	logic [6:0]  scan_addr;
	logic [7:0]  scan_rdata;

	// column maps to a byte; narrow modes start past the eight free bytes
	always_comb
	begin
		scan_addr = {com_ff[3], wide ? col_ff : col_ff + LMFC_SKIP_LOW};
	end

	// one byte per mclk, so a slot's 48 columns load long before it ends
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_com    = com_ff;
		nxt_col    = col_ff;
		nxt_pend   = 1'b0;
		nxt_shadow = shadow_ff;
		nxt_seg    = seg_ff;
		nxt_cpl    = cpl_ff;
		nxt_drv    = drv_ff;
		nxt_merge  = active && (ctrl_ff.ratio != LMFC_RATIO_SEL_SIXTEEN);
		if (pend_ff)
			nxt_shadow[pend_col_ff] = scan_rdata[com_ff[2:0]]
				&& (wide || pend_col_ff < 6'(LMFC_SEG_NARROW));
		if (!active)
		begin
			nxt_state = LMFC_ST_IDLE;
			nxt_com   = 4'h0;
			nxt_seg   = '0;
			nxt_cpl   = '0;
			nxt_drv   = 1'b0;
		end
		else if (cpu_req.wr && ctrl_sel)
		begin
			// a new mode restarts at common 1 so no stale common outlives it
			nxt_state = LMFC_ST_IDLE;
			nxt_com   = 4'h0;
		end
		else
		begin
			unique case (state_ff)
				LMFC_ST_IDLE:
				begin
					nxt_col = 6'h00;
					if (slot_tick)
						nxt_state = LMFC_ST_FETCH;
				end
				LMFC_ST_FETCH:
				begin
					nxt_pend = 1'b1;
					nxt_col  = col_ff + 6'h01;
					if (col_ff == 6'(LMFC_SEG_WIDE - 1))
						nxt_state = LMFC_ST_LATCH;
				end
				LMFC_ST_LATCH:
				begin
					// commons step in order and wrap after the last enabled one
					nxt_seg   = nxt_shadow;
					nxt_cpl   = 16'h0001 << com_ff;
					nxt_drv   = 1'b1;
					nxt_com   = ({1'b0, com_ff} >= ncom - 5'h01) ? 4'h0 : com_ff + 4'h1;
					nxt_state = LMFC_ST_IDLE;
				end
				default:
					nxt_state = LMFC_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_ff    <= LMFC_ST_IDLE;
			com_ff      <= 4'h0;
			col_ff      <= 6'h00;
			pend_ff     <= 1'b0;
			pend_col_ff <= 6'h00;
			shadow_ff   <= '0;
			seg_ff      <= '0;
			cpl_ff      <= '0;
			drv_ff      <= 1'b0;
			merge_ff    <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			com_ff      <= nxt_com;
			col_ff      <= nxt_col;
			pend_ff     <= nxt_pend;
			pend_col_ff <= col_ff;
			shadow_ff   <= nxt_shadow;
			seg_ff      <= nxt_seg;
			cpl_ff      <= nxt_cpl;
			drv_ff      <= nxt_drv;
			merge_ff    <= nxt_merge;
		end
	end

	lmfc_disp_ram #(
		.ADDR_W (7)
	) u_ram (
		.mclk       (mclk),
		.rst_sync_n (rst_sync_n),
		.cpu_we     (cpu_req.wr && ram_sel),
		.cpu_addr   ({cpu_req.page, cpu_req.addr[5:0]}),
		.cpu_wdata  (cpu_req.wdata),
		.cpu_rdata  (ram_cpu_rdata),
		.scan_addr  (scan_addr),
		.scan_rdata (scan_rdata)
	);

	assign seg_lines          = seg_ff;
	assign common_plate_lines = cpl_ff;
	assign lines_driven       = drv_ff;
	assign bias_merge         = merge_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_n);

	AST_STOP_GROUND: assert property (stop_mode |=>
		seg_lines == 48'h0 && common_plate_lines == 16'h0 && !lines_driven)
		else $error("lines not grounded in stop mode");
	AST_FAIL_GROUND: assert property ($rose(fail_sync_ff) |=>
		seg_lines == 48'h0 && common_plate_lines == 16'h0)
		else $error("lines not grounded after oscillator failure");
	AST_ONE_COMMON: assert property (lines_driven |-> $onehot(common_plate_lines))
		else $error("not exactly one common active");
	AST_COMMON_RANGE: assert property (ctrl_ff.ratio == LMFC_MUX8 && $stable(ctrl_ff)
		&& state_ff == LMFC_ST_LATCH |=> common_plate_lines[15:8] == 8'h00)
		else $error("common above eight driven in 1/8 mode");
	AST_NARROW_SEG: assert property (!wide && state_ff == LMFC_ST_LATCH
		&& $stable(ctrl_ff.ratio) |=> seg_lines[47:40] == 8'h00)
		else $error("segment above forty driven in narrow mode");
	AST_FREE_BYTES: assert property (state_ff == LMFC_ST_FETCH && (wide
		|| col_ff < 6'(LMFC_SEG_NARROW)) |-> scan_addr[5:0] < LMFC_FREE_FIRST)
		else $error("display fetch touched free bytes");
	AST_PAGE_ONE: assert property (wide && state_ff == LMFC_ST_FETCH
		|-> !scan_addr[6])
		else $error("page two fetched in 1/8 mode");
	AST_SKIP_LOW: assert property (!wide && state_ff == LMFC_ST_FETCH
		|-> scan_addr[5:0] >= LMFC_SKIP_LOW)
		else $error("low bytes fetched in narrow mode");
	AST_ELEVEN_BITS: assert property (ctrl_ff.ratio == LMFC_RATIO_SEL_ELEVEN
		&& state_ff == LMFC_ST_FETCH |-> com_ff < 4'hB)
		else $error("page two upper bits used in 1/11 mode");
	AST_CTRL_WRITE: assert property (cpu_req.wr && ctrl_sel |=>
		ctrl_ff == lmfc_ctrl_t'($past(cpu_req.wdata) & ~LMFC_CTRL_RSVD_MSK))
		else $error("mode register write not stored");
	AST_BIAS_MERGE: assert property (active && ctrl_ff.ratio == LMFC_RATIO_SEL_SIXTEEN
		&& $stable(ctrl_ff) |=> !bias_merge)
		else $error("bias levels merged in 1/16 mode");
	AST_DIV_OFF: assert property (ctrl_ff.osc_div == 3'b000 |=>
		!lines_driven && seg_lines == 48'h0)
		else $error("display on with divider stopped");

	COV_WIDE_SHOW: cover property (wide && state_ff == LMFC_ST_LATCH);
	COV_SIXTEEN_WRAP: cover property (ctrl_ff.ratio == LMFC_RATIO_SEL_SIXTEEN && common_plate_lines[15]);
	COV_STOP_ENTRY: cover property (lines_driven ##1 stop_mode);
endmodule

// ==== logic/lmfc_pkg.sv ====
// shared constants, types and decoders of the multiplexed lcd frame controller
package lmfc_pkg;

	// ****************************************
	// register map and field layout
	// ****************************************
	localparam logic [7:0] LMFC_CTRL_ADDR     = 8'hDC;
	localparam logic [7:0] LMFC_RAM_LAST_ADDR = 8'h3F;
	localparam logic [7:0] LMFC_CTRL_RESET    = 8'h00;
	localparam logic [7:0] LMFC_CTRL_RSVD_MSK = 8'h04;
	localparam int         LMFC_RATIO_POS     = 6;
	localparam int         LMFC_OSC_DIV_POS   = 3;
	localparam int         LMFC_BASE_RATE_POS = 0;

	// ****************************************
	// display geometry
	// ****************************************
	localparam int         LMFC_SEG_WIDE      = 48;
	localparam int         LMFC_SEG_NARROW    = 40;
	localparam int         LMFC_COM_MAX       = 16;
	localparam logic [5:0] LMFC_SKIP_LOW      = 6'h08;
	localparam logic [5:0] LMFC_FREE_FIRST    = 6'h38;

	// ****************************************
	// timing counts in mclk and 32 kHz ticks
	// ****************************************
	localparam logic [8:0] LMFC_OSC_DIV_32    = 9'h020;
	localparam logic [8:0] LMFC_OSC_DIV_64    = 9'h040;
	localparam logic [8:0] LMFC_OSC_DIV_128   = 9'h080;
	localparam logic [8:0] LMFC_OSC_DIV_256   = 9'h100;
	localparam logic [8:0] LMFC_BASE_DIV_128  = 9'h100;
	localparam logic [8:0] LMFC_BASE_DIV_170  = 9'h0C0;
	localparam logic [8:0] LMFC_BASE_DIV_256  = 9'h080;
	localparam logic [8:0] LMFC_BASE_DIV_512  = 9'h040;
	localparam int         LMFC_SLOTS_PER_BASE = 8;

	// ratio code is {sixteen select, eleven select}
	typedef enum logic [1:0] {
		LMFC_MUX8   = 2'b00,
		LMFC_RATIO_SEL_ELEVEN  = 2'b01,
		LMFC_RATIO_SEL_SIXTEEN  = 2'b10,
		LMFC_MUXRSV = 2'b11
	} lmfc_mux_t;

	typedef struct packed {
		logic [1:0] ratio;
		logic [2:0] osc_div;
		logic       rsvd;
		logic [1:0] base_rate;
	} lmfc_ctrl_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lmfc_cpu_req_t;

	// main clock divider for the 32 kHz reference, zero when stopped
	function automatic logic [8:0] lmfc_osc_div(input logic [2:0] code);
		unique case (code)
			3'b011:  return LMFC_OSC_DIV_32;
			3'b100:  return LMFC_OSC_DIV_64;
			3'b101:  return LMFC_OSC_DIV_128;
			3'b110:  return LMFC_OSC_DIV_256;
			default: return 9'h000;
		endcase
	endfunction

	// 32 kHz ticks per common slot: base divider spread over eight slots
	function automatic logic [5:0] lmfc_slot_len(input logic [1:0] code);
		logic [8:0] div;
		unique case (code)
			2'b01:   div = LMFC_BASE_DIV_128;
			2'b10:   div = LMFC_BASE_DIV_170;
			2'b00:   div = LMFC_BASE_DIV_256;
			default: div = LMFC_BASE_DIV_512;
		endcase
		return div[8:3];
	endfunction

	function automatic logic [4:0] lmfc_common_count(input logic [1:0] ratio);
		unique case (ratio)
			LMFC_MUX8:  return 5'h08;
			LMFC_RATIO_SEL_ELEVEN: return 5'h0B;
			LMFC_RATIO_SEL_SIXTEEN: return 5'h10;
			default:    return 5'h00;
		endcase
	endfunction

endpackage

// ==== logic/lmfc_rate_gen.sv ====
// divider chain: main clock to 32 kHz reference to common slot enable
`timescale 1ns/1ps
module lmfc_rate_gen
	import lmfc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_sync_n,
	input  wire logic       run,
	input  wire logic [2:0] osc_code,
	input  wire logic [1:0] base_code,
	output logic            slot_tick
);
	logic [8:0] osc_cnt_ff;
	logic [8:0] nxt_osc_cnt;
	logic [5:0] slot_cnt_ff;
	logic [5:0] nxt_slot_cnt;
	logic       tick_ref;
	logic [8:0] osc_div;
	logic [5:0] slot_len;

	// ****************************************
	// counters
	// ****************************************
	// both counters restart from zero whenever the controller is off
	always_comb
	begin
		osc_div      = lmfc_osc_div(osc_code);
		slot_len     = lmfc_slot_len(base_code);
		tick_ref     = run && (osc_cnt_ff >= osc_div - 9'h001);
		slot_tick    = tick_ref && (slot_cnt_ff >= slot_len - 6'h01);
		nxt_osc_cnt  = (!run || tick_ref) ? 9'h000 : osc_cnt_ff + 9'h001;
		nxt_slot_cnt = slot_cnt_ff;
		if (!run || slot_tick)
			nxt_slot_cnt = 6'h00;
		else if (tick_ref)
			nxt_slot_cnt = slot_cnt_ff + 6'h01;
	end

	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			osc_cnt_ff  <= 9'h000;
			slot_cnt_ff <= 6'h00;
		end
		else
		begin
			osc_cnt_ff  <= nxt_osc_cnt;
			slot_cnt_ff <= nxt_slot_cnt;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_REF_SPACING: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		tick_ref && $stable(osc_code) |=> !tick_ref [*8])
		else $error("reference tick faster than smallest divider");
	AST_STOPPED_QUIET: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		!run |-> !slot_tick)
		else $error("slot enable while divider is off");
endmodule

// ==== logic/lmfc_disp_ram.sv ====
// two-page display memory with a cpu port and a scan read port
`timescale 1ns/1ps
module lmfc_disp_ram #(
	parameter int ADDR_W = 7
) (
	input  wire logic              mclk,
	input  wire logic              rst_sync_n,
	input  wire logic              cpu_we,
	input  wire logic [ADDR_W-1:0] cpu_addr,
	input  wire logic [7:0]        cpu_wdata,
	output logic      [7:0]        cpu_rdata,
	input  wire logic [ADDR_W-1:0] scan_addr,
	output logic      [7:0]        scan_rdata
);
	// elaboration check: the page select is the top address bit
	if (ADDR_W != 7)
		$error("display memory needs exactly two pages of 64 bytes");

	logic [7:0] mem [0:(1<<ADDR_W)-1];

	// contents are deliberately left uninitialised by reset
	always_ff @(posedge mclk)
	begin
		if (cpu_we)
			mem[cpu_addr] <= cpu_wdata;
	end

	// registered reads; the cpu and scan ports never disturb each other
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			cpu_rdata  <= 8'h00;
			scan_rdata <= 8'h00;
		end
		else
		begin
			cpu_rdata  <= mem[cpu_addr];
			scan_rdata <= mem[scan_addr];
		end
	end
endmodule

// ==== tb/lmfc_panel.sv ====
// behavioural model of the multiplexed glass panel on the line outputs
`timescale 1ns/1ps
module lmfc_panel
	import lmfc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [47:0] seg_lines,
	input  wire logic [15:0] common_plate_lines,
	input  wire logic        lines_driven,
	output logic             fault
);
	import lmfc_pkg::*;
	initial fault = 1'b0;
	// ****************************************
	// dc bias watch
	// ****************************************
	// a grounded panel must see no line high; a driven one exactly one common
	always @(posedge mclk)
	begin
		if (lines_driven === 1'b0 && (seg_lines !== 48'h0 || common_plate_lines !== 16'h0))
			fault <= 1'b1;
		if (lines_driven === 1'b1 && !$onehot(common_plate_lines))
			fault <= 1'b1;
	end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the lcd frame controller
`timescale 1ns/1ps
module testbench;
	import lmfc_pkg::*;
	logic          mclk;
	logic          rst_n;
	lmfc_cpu_req_t cpu_req;
	logic [7:0]    cpu_rdata;
	logic          stop_mode;
	logic          osc_fail_async;
	logic [47:0]   seg_lines;
	logic [15:0]   common_plate_lines;
	logic          lines_driven;
	logic          bias_merge;
	logic          fault;
	int            miscompares = 0;
	int            cmp_count = 0;
	int            n;
	int            base_per[4] = '{128, 256, 192, 64};

	lmfc_frame_ctrl dut (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
		.stop_mode(stop_mode), .osc_fail_async(osc_fail_async), .seg_lines(seg_lines),
		.common_plate_lines(common_plate_lines), .lines_driven(lines_driven),
		.bias_merge(bias_merge));
	lmfc_panel panel (.mclk(mclk), .seg_lines(seg_lines),
		.common_plate_lines(common_plate_lines), .lines_driven(lines_driven), .fault(fault));

	// ****************************************
	// clock and watchdog
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// the planned run is near 54k cycles, so 90k means a hang
	initial
	begin
		repeat (90000) @(posedge mclk);
		miscompares++;
		close_out();
	end

	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// strobes set at a falling edge, taken at the rising edge after
	task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		cpu_req = '{1'b1, 1'b0, p, a, d};
		@(negedge mclk);
		cpu_req = '{1'b0, 1'b0, 1'b0, 8'h00, 8'h00};
	endtask
	// read data stands the cycle after the strobe edge
	task automatic rd(input logic p, input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk);
		cpu_req = '{1'b0, 1'b1, p, a, 8'h00};
		@(negedge mclk);
		cpu_req = '{1'b0, 1'b0, 1'b0, 8'h00, 8'h00};
		chk(48'(cpu_rdata), 48'(exp));
	endtask
	// bounded wait for the next common slot change, n is the slot length
	task automatic wait_chg(output int cnt);
		logic [15:0] prev;
		prev = common_plate_lines;
		cnt = 0;
		while (common_plate_lines === prev && cnt < 5000)
		begin
			@(negedge mclk);
			cnt++;
		end
		if (cnt >= 5000)
		begin
			miscompares++;
			$display("BAD %0t slot wait %0h", $time, prev);
		end
	endtask
	function automatic logic [7:0] patt(input logic p, input logic [7:0] a);
		return a ^ (p ? 8'hA5 : 8'h3C);
	endfunction
	// wide mode: column c is page 1 byte c; narrow: byte c+8, top 8 columns blank
	function automatic logic [47:0] exp_seg(input int k, input bit nar);
		logic [47:0] s;
		logic [7:0]  b;
		s = 48'h0;
		for (int c = 0; c < 48; c++)
		begin
			if (!nar)
				b = patt(1'b0, 8'(c));
			else if (c < 40)
				b = patt(k >= 8, 8'(c + 8));
			else
				b = 8'h00;
			s[c] = b[k % 8];
		end
		return s;
	endfunction
	// one full frame from common 1, plus the wrap back to common 1
	task automatic frame(input logic [7:0] ctrl, input int nc, input bit nar, input logic mrg);
		wr(1'b0, LMFC_CTRL_ADDR, ctrl);
		// at least one slot in the new mode before looking for common 1
		wait_chg(n);
		for (int i = 0; i < 18 && common_plate_lines !== 16'h0001; i++)
			wait_chg(n);
		for (int k = 0; k <= nc; k++)
		begin
			chk(48'(common_plate_lines), 48'(16'h0001 << (k % nc)));
			chk(seg_lines, exp_seg(k % nc, nar));
			chk(48'({lines_driven, bias_merge}), 48'({1'b1, mrg}));
			if (k < nc)
				wait_chg(n);
		end
		chk(48'(n), 48'(512));
	endtask
	task automatic period(input logic [7:0] ctrl, input int exp);
		wr(1'b0, LMFC_CTRL_ADDR, ctrl);
		wait_chg(n);
		wait_chg(n);
		wait_chg(n);
		chk(48'(n), 48'(exp));
	endtask
	task automatic lines_off();
		repeat (4) @(negedge mclk);
		chk(seg_lines, 48'h0);
		chk(48'({common_plate_lines, lines_driven}), 48'h0);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rst_n = 1'b0;
		cpu_req = '{1'b0, 1'b0, 1'b0, 8'h00, 8'h00};
		stop_mode = 1'b0;
		osc_fail_async = 1'b0;
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		rd(1'b0, LMFC_CTRL_ADDR, 8'h00);
		lines_off();
		// reserved bit reads back clear
		wr(1'b0, LMFC_CTRL_ADDR, 8'hFF);
		rd(1'b0, LMFC_CTRL_ADDR, 8'hFB);
		rd(1'b0, 8'h50, 8'h00);
		for (int a = 0; a < 64; a++)
		begin
			wr(1'b0, 8'(a), patt(1'b0, 8'(a)));
			wr(1'b1, 8'(a), patt(1'b1, 8'(a)));
		end
		rd(1'b0, 8'h00, patt(1'b0, 8'h00));
		rd(1'b1, 8'h3F, patt(1'b1, 8'h3F));
		rd(1'b0, 8'h3F, patt(1'b0, 8'h3F));
		// frames in each ratio at /32 and 16 ticks per slot
		frame(8'h18, 8, 1'b0, 1'b1);
		frame(8'h98, 16, 1'b1, 1'b0);
		frame(8'h58, 11, 1'b1, 1'b1);
		for (int c = 0; c < 4; c++)
			period(8'h18 | 8'(c), 32 * base_per[c] / 8);
		for (int d = 3; d < 7; d++)
			period({2'b00, 3'(d), 3'b011}, 8 * (32 << (d - 3)));
		// reserved ratio and stopped divider blank the panel
		wr(1'b0, LMFC_CTRL_ADDR, 8'hD8);
		lines_off();
		wr(1'b0, LMFC_CTRL_ADDR, 8'h80);
		lines_off();
		wr(1'b0, LMFC_CTRL_ADDR, 8'h1B);
		wait_chg(n);
		stop_mode = 1'b1;
		lines_off();
		stop_mode = 1'b0;
		wait_chg(n);
		osc_fail_async = 1'b1;
		lines_off();
		osc_fail_async = 1'b0;
		wait_chg(n);
		chk(48'(lines_driven), 48'h1);
		// second reset clears the mode register but keeps the memory
		rst_n = 1'b0;
		repeat (3) @(negedge mclk);
		lines_off();
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		rd(1'b0, LMFC_CTRL_ADDR, 8'h00);
		rd(1'b1, 8'h21, patt(1'b1, 8'h21));
		chk(48'(fault), 48'h0);
		close_out();
	end
endmodule
